// >>> design/dac_load_host.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (RL1) Select low only during each write; the host holds it low from the first write through the last of the four.
// (RL2) Write strobe low selects latch with address.
// (RL3) Update low copies input latches to channels.
// (RL4) Upper address line is the most significant.
// (RL5) Upper bus lines carry code bits 7..4.
// (RL6) Lower lines carry bits 3..0 or 11..8.
// (RL7) Addresses 00,01,10,11 pick A low..B high.
// (RL8) Update with select, write high loads both.
// (RL9) Channel code is 12 bits: byte plus nibble.
module dac_load_host
	import dac_load_pkg::*;
(
	input wire logic ref_clk, // System clock, 10 MHz.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic req_valid, // A pair of codes is offered.
	input wire dac_req_s req, // Codes for channels A and B.
	output logic req_ready, // Host idle, request would be taken.
	output logic busy, // A load sequence is running.
	output dac_pins_s pins // Pins towards the converter.
);

	// Whole module state.
	typedef struct packed {
		phase_e phase;
		logic [1:0] addr;
		logic [3:0] cnt;
		dac_req_s codes;
		dac_pins_s pins;
		logic ready;
		logic busy;
	} state_s;

	state_s st_q; // Registered state.
	state_s st_d; // Next state.

	// Byte of a code that goes to the bus for a given latch address.
	function automatic logic [7:0] byte_for(input logic [1:0] a,
		input dac_req_s c);
		logic [11:0] code;
		code = a[1] ? c.code_b : c.code_a; // RL4
		if (a[0]) begin
			byte_for = {4'h0, code[11:8]}; // RL6 RL9
		end else begin
			byte_for = code[7:0]; // RL5 RL6
		end
	endfunction

	// Next-state logic of the load sequencer.
	always_comb begin
		logic [7:0] b;
		b = 8'h00;
		st_d = st_q;
		case (st_q.phase)
			ST_IDLE: begin
				// Wait for a request with all strobes parked high.
				if (req_valid) begin
					st_d.codes = req;
					st_d.addr = ADDR_A_LOW;
					st_d.ready = 1'b0;
					st_d.busy = 1'b1;
					st_d.cnt = CNT_RESET;
					st_d.phase = ST_SETUP;
					b = byte_for(ADDR_A_LOW, req);
					st_d.pins.latch_sel_hi = ADDR_A_LOW[1]; // RL4 RL7
					st_d.pins.latch_sel_lo = ADDR_A_LOW[0]; // RL4 RL7
					st_d.pins.bus_bits_upper = b[7:4]; // RL5
					st_d.pins.bus_bits_lower = b[3:0]; // RL6
					st_d.pins.select_n = 1'b0; // RL1
				end
			end
			ST_SETUP: begin
				// Address, data and select settle before the strobe.
				if (st_q.cnt >= 4'(SETUP_CYC - 1)) begin
					st_d.cnt = CNT_RESET;
					st_d.pins.write_n = 1'b0; // RL2
					st_d.phase = ST_STROBE;
				end else begin
					st_d.cnt = st_q.cnt + 4'h1;
				end
			end
			ST_STROBE: begin
				// Strobe stays low for the least pulse width.
				if (st_q.cnt >= 4'(WR_PULSE_CYC - 1)) begin
					st_d.cnt = CNT_RESET;
					st_d.pins.write_n = 1'b1; // RL2
					st_d.phase = ST_HOLD;
				end else begin
					st_d.cnt = st_q.cnt + 4'h1;
				end
			end
			ST_HOLD: begin
				// Hold data and address after the rising strobe edge.
				if (st_q.cnt >= 4'(HOLD_CYC - 1)) begin
					st_d.cnt = CNT_RESET;
					st_d.pins.select_n = 1'b1; // RL1
					if (st_q.addr == ADDR_B_HIGH) begin
						st_d.pins.channel_update_n = 1'b0; // RL3 RL8
						st_d.phase = ST_UPDATE;
					end else begin
						st_d.addr = st_q.addr + 2'h1; // RL7
						b = byte_for(st_d.addr, st_q.codes);
						st_d.pins.latch_sel_hi = st_d.addr[1]; // RL4
						st_d.pins.latch_sel_lo = st_d.addr[0]; // RL4
						st_d.pins.bus_bits_upper = b[7:4]; // RL5
						st_d.pins.bus_bits_lower = b[3:0]; // RL6
						st_d.pins.select_n = 1'b0; // RL1
						st_d.phase = ST_SETUP;
					end
				end else begin
					st_d.cnt = st_q.cnt + 4'h1;
				end
			end
			ST_UPDATE: begin
				// Update pulse while select and write stay high.
				if (st_q.cnt >= 4'(UPD_PULSE_CYC - 1)) begin
					st_d.cnt = CNT_RESET;
					st_d.pins.channel_update_n = 1'b1; // RL3
					st_d.ready = 1'b1;
					st_d.busy = 1'b0;
					st_d.phase = ST_IDLE;
				end else begin
					st_d.cnt = st_q.cnt + 4'h1;
				end
			end
			default: begin
				st_d.phase = ST_IDLE;
			end
		endcase
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_q <= '{phase: ST_IDLE, addr: ADDR_A_LOW, cnt: CNT_RESET,
				codes: '0,
				pins: '{select_n: 1'b1, write_n: 1'b1,
					channel_update_n: 1'b1, latch_sel_hi: ADDR_A_LOW[1],
					latch_sel_lo: ADDR_A_LOW[0],
					bus_bits_upper: BUS_RESET[7:4],
					bus_bits_lower: BUS_RESET[3:0]},
				ready: 1'b1, busy: 1'b0};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign pins = st_q.pins;
	assign req_ready = st_q.ready;
	assign busy = st_q.busy;

	// Strobe only falls while the chip is selected.
	property p_wr_in_sel;
		@(posedge ref_clk) disable iff (reset)
		!pins.write_n |-> !pins.select_n;
	endproperty
	a_wr_in_sel: assert property (p_wr_in_sel) // RL1
		else $error("Write strobe low without select.");

	// Write and update never overlap.
	property p_upd_excl;
		@(posedge ref_clk) disable iff (reset)
		!pins.channel_update_n |-> pins.write_n && pins.select_n;
	endproperty
	a_upd_excl: assert property (p_upd_excl) // RL8
		else $error("Update low while a write is active.");

	// Address steady while strobe is low.
	property p_addr_stable;
		@(posedge ref_clk) disable iff (reset)
		(!pins.write_n && !$past(pins.write_n)) |->
			$stable({pins.latch_sel_hi, pins.latch_sel_lo});
	endproperty
	a_addr_stable: assert property (p_addr_stable) // RL4
		else $error("Address moved during the write strobe.");

	// High-byte write carries a clean upper nibble.
	property p_high_nibble;
		@(posedge ref_clk) disable iff (reset)
		(!pins.write_n && pins.latch_sel_lo) |->
			pins.bus_bits_upper == 4'h0;
	endproperty
	a_high_nibble: assert property (p_high_nibble) // RL6
		else $error("Upper bus lines not zero on high byte.");

	// Channel A low byte carries bits 7..0 of code A.
	property p_low_byte;
		@(posedge ref_clk) disable iff (reset)
		(!pins.write_n && !pins.latch_sel_hi && !pins.latch_sel_lo) |->
			{pins.bus_bits_upper, pins.bus_bits_lower} ==
			st_q.codes.code_a[7:0];
	endproperty
	a_low_byte: assert property (p_low_byte) // RL5
		else $error("Low byte of channel A is wrong.");

	// Channel B high byte carries bits 11..8 of code B.
	property p_b_high;
		@(posedge ref_clk) disable iff (reset)
		(!pins.write_n && pins.latch_sel_hi && pins.latch_sel_lo) |->
			pins.bus_bits_lower == st_q.codes.code_b[11:8];
	endproperty
	a_b_high: assert property (p_b_high) // RL9
		else $error("High nibble of channel B is wrong.");

	// Update follows the write to the last latch.
	sequence s_last_write;
		!pins.write_n && pins.latch_sel_hi && pins.latch_sel_lo;
	endsequence
	property p_upd_after;
		@(posedge ref_clk) disable iff (reset || !clk_en)
		s_last_write ##1 pins.write_n |-> ##[1:8] !pins.channel_update_n;
	endproperty
	a_upd_after: assert property (p_upd_after) // RL3
		else $error("No update after the last write.");

	// A taken request starts the channel A low write.
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_first_addr;
		!pins.select_n && !pins.latch_sel_hi && !pins.latch_sel_lo;
	endsequence
	property p_start;
		@(posedge ref_clk) disable iff (reset || !clk_en)
		s_take |-> ##1 s_first_addr ##1 !pins.write_n;
	endproperty
	a_start: assert property (p_start) // RL2 RL7
		else $error("Sequence did not start at channel A low.");

endmodule // dac_load_host
`default_nettype wire

// >>> design/dac_load_pkg.sv
`default_nettype none
package dac_load_pkg;

	// Latch addresses on the two select lines.
	localparam logic [1:0] ADDR_A_LOW = 2'h0;
	localparam logic [1:0] ADDR_A_HIGH = 2'h1;
	localparam logic [1:0] ADDR_B_LOW = 2'h2;
	localparam logic [1:0] ADDR_B_HIGH = 2'h3;

	// Code layout: the low byte and the upper nibble of a 12-bit code.
	localparam int CODE_W = 12;
	localparam int LOW_W = 8;
	localparam int HIGH_W = 4;

	// Pin timing minimums in nanoseconds.
	localparam int CLK_PERIOD_NS = 100;
	localparam int WR_PULSE_NS = 100;
	localparam int DATA_SETUP_NS = 80;
	localparam int ADDR_SETUP_NS = 15;
	localparam int HOLD_NS = 15;
	localparam int UPD_PULSE_NS = 100;

	// Cycle counts, least times rounded up, never below one.
	localparam int WR_PULSE_CYC =
		(WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC_RAW =
		(DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
	localparam int HOLD_CYC =
		((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UPD_PULSE_CYC =
		(UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_SETUP_CYC =
		((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values of the bus pins and of the phase counter.
	localparam logic [7:0] BUS_RESET = 8'h00;
	localparam logic [3:0] CNT_RESET = 4'h0;

	// Sequencer phases.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_UPDATE
	} phase_e;

	// The pins driven towards the converter.
	typedef struct packed {
		logic select_n;
		logic write_n;
		logic channel_update_n;
		logic latch_sel_hi;
		logic latch_sel_lo;
		logic [3:0] bus_bits_upper;
		logic [3:0] bus_bits_lower;
	} dac_pins_s;

	// The request from user logic: both channel codes.
	typedef struct packed {
		logic [11:0] code_a;
		logic [11:0] code_b;
	} dac_req_s;

endpackage
`default_nettype wire

// >>> testbench/dac_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module dac_device_model
	import dac_load_pkg::*;
(
	input wire dac_pins_s pins, // Pins from the host.
	output logic [11:0] chan_a, // Channel A code.
	output logic [11:0] chan_b // Channel B code.
);
	logic [7:0] a_low, b_low; // Low-byte input latches.
	logic [3:0] a_high, b_high; // Upper-nibble input latches.
	logic [1:0] addr; // Latch address.
	logic [7:0] bus; // Whole data bus.
	assign addr = {pins.latch_sel_hi, pins.latch_sel_lo};
	assign bus = {pins.bus_bits_upper, pins.bus_bits_lower};
	// An input latch follows the bus while selected and strobed.
	always_latch begin
		if (!pins.select_n && !pins.write_n &&
			pins.channel_update_n) begin
			case (addr)
				ADDR_A_LOW: a_low <= bus;
				ADDR_A_HIGH: a_high <= bus[3:0];
				ADDR_B_LOW: b_low <= bus;
				default: b_high <= bus[3:0];
			endcase
		end
	end
	// Both channels load together, only with select and write idle.
	always_latch begin
		if (!pins.channel_update_n && pins.select_n && pins.write_n) begin
			chan_a <= {a_high, a_low};
			chan_b <= {b_high, b_low};
		end
	end
endmodule // dac_device_model
`default_nettype wire

// >>> testbench/dual_dac_byte_load_interface_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dual_dac_byte_load_interface_bench
	import dac_load_pkg::*;
;
	logic ref_clk, reset, clk_en, req_valid; // Stimulus.
	dac_req_s req; // Offered codes.
	logic req_ready, busy; // Host status.
	dac_pins_s pins; // Pins to the device.
	logic [11:0] chan_a, chan_b; // Device channel codes.
	logic [12:0] held; // Pins saved at a freeze.
	int failures, n_tests; // Tallies.
	// Each row: codes offered, then the channel codes they should leave.
	logic [47:0] rows [5] = '{48'h000FFF_000FFF, 48'hFFF000_FFF000,
		48'hA5C35A_A5C35A, 48'h8017FE_8017FE, 48'h0F0F0F_0F0F0F};
	dac_load_host DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.busy(busy), .pins(pins));
	dac_device_model device (.pins(pins), .chan_a(chan_a),
		.chan_b(chan_b));
	// Compares and reports one value.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Offers one pair of codes for a single cycle.
	task automatic offer(input dac_req_s r);
		@(negedge ref_clk);
		req_valid = 1'b1;
		req = r;
		@(negedge ref_clk);
		req_valid = 1'b0;
	endtask
	// Waits, bounded, until the host is idle again.
	task automatic await_idle();
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk);
		while (busy !== 1'b0 || req_ready !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > 40) begin
				failures++;
				break;
			end
		end
	endtask
	// Watches the strobe and update pins for illegal overlaps.
	always @(negedge ref_clk) begin
		if (pins.write_n === 1'b0) check(pins.select_n, 1'b0);
		if (pins.channel_update_n === 1'b0) begin
			check({pins.select_n, pins.write_n}, 2'h3);
		end
	end
	// Clock of 100 ns.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Watchdog at 5000 cycles, far beyond the under 200 cycles needed.
	initial begin
		#500000;
		failures++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		req_valid = 1'b0;
		req = '0;
		// Two rising edges under reset, whatever the start-up order.
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check({busy, req_ready, pins}, {2'h1, 13'h1C00});
		reset = 1'b0;
		foreach (rows[i]) begin
			offer(rows[i][47:24]);
			await_idle();
			check({chan_a, chan_b}, rows[i][23:0]);
		end
		// A request offered while busy is refused.
		offer(24'h123456);
		@(negedge ref_clk);
		req_valid = 1'b1;
		req = 24'hABCDEF;
		repeat (4) @(negedge ref_clk);
		check({chan_a, chan_b}, 24'h0F0F0F);
		req_valid = 1'b0;
		await_idle();
		check({chan_a, chan_b}, 24'h123456);
		// A freeze in mid-load holds every pin.
		offer(24'h987654);
		repeat (3) @(negedge ref_clk);
		clk_en = 1'b0;
		held = pins;
		repeat (5) @(negedge ref_clk);
		check(pins, held);
		clk_en = 1'b1;
		await_idle();
		check({chan_a, chan_b}, 24'h987654);
		// A reset in mid-load leaves the channels alone.
		offer(24'h111222);
		repeat (5) @(negedge ref_clk);
		reset = 1'b1;
		@(negedge ref_clk);
		check({busy, req_ready, pins}, {2'h1, 13'h1C00});
		reset = 1'b0;
		check({chan_a, chan_b}, 24'h987654);
		offer(24'hFEDCBA);
		await_idle();
		check({chan_a, chan_b}, 24'hFEDCBA);
		tally_and_finish();
	end
endmodule // dual_dac_byte_load_interface_bench
`default_nettype wire
